/* hw/dsr_pkg.sv */
// dsr_pkg: shared constants and carriers for the deceleration stall ramp block
// assumes one 25 MHz clock and plain-port configuration from the control core
`default_nettype none
package dsr_pkg;
	// ************************************************************
	// widths and encodings
	// ************************************************************
	localparam int FREQ_W = 16;
	localparam int VOLT_W = 11;
	localparam int ADC_W = 12;
	localparam int GAIN_W = 14;
	localparam int RATE_W = 16;

	typedef enum logic [1:0] {DSR_OFF, DSR_HOLD, DSR_SMART, DSR_BRAKE} dsr_mode_t;
	typedef enum logic [2:0] {DSR_VF, DSR_VF_PG, DSR_OLV1, DSR_FLUX, DSR_OLV2} dsr_ctrl_t;

	localparam logic [1:0] MODE_RESET = 2'h1;
	localparam logic MODE_MAX_OK = 1'h1;
	localparam logic LEVEL_RESET = 1'h0;
	localparam logic [GAIN_W-1:0] GAIN_RESET = 14'h03E8;   // 100.0 %, 0.1 % units
	localparam logic [GAIN_W-1:0] GAIN_MAX = 14'h2710;     // 1000.0 %
	localparam logic [GAIN_W-1:0] GAIN_UNITY = 14'h03E8;

	// stall levels in volts
	localparam logic [VOLT_W-1:0] STALL_LOW_CLASS = 11'h17C;  // 380 V
	localparam logic [VOLT_W-1:0] STALL_HIGH_HI = 11'h2F8;    // 760 V
	localparam logic [VOLT_W-1:0] STALL_HIGH_LO = 11'h294;    // 660 V
	localparam logic [VOLT_W-1:0] INPUT_V_SPLIT = 11'h190;    // 400 V

	// analog full scale (10 V) in adc counts, 11 bits + sign
	localparam logic [ADC_W-2:0] ADC_FULL = 11'h7FF;
	// adaptive rate step, in frequency units per tick
	localparam logic [RATE_W-1:0] SMART_STEP = 16'h0001;

	typedef struct packed {
		dsr_mode_t mode;
		logic high_class;
		logic [VOLT_W-1:0] input_voltage_setting;
		dsr_ctrl_t ctrl;
	} dsr_cfg_t;
endpackage : dsr_pkg
`default_nettype wire

/* hw/dsr_analog_ref.sv */
// dsr_analog_ref: first analog input level select and gain scaling
// assumes adc sample is already synchronous to clk
`default_nettype none
module dsr_analog_ref
	import dsr_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic level_sel,
	input wire logic [GAIN_W-1:0] gain,
	input wire logic [ADC_W-1:0] first_analog_input,
	input wire logic [FREQ_W-1:0] max_freq,
	output logic signed [FREQ_W:0] freq_ref
);
	// ************************************************************
	// scaling
	// ************************************************************
	logic [ADC_W-2:0] mag;
	logic neg;
	logic [FREQ_W+GAIN_W+ADC_W-2:0] prod;
	logic [FREQ_W+GAIN_W+ADC_W-2:0] scaled;
	logic [FREQ_W-1:0] mag_ref;

	// level 0 uses sign-magnitude; level 1 ignores the sign bit and takes the 11-bit magnitude
	assign neg = first_analog_input[ADC_W-1] & ~level_sel;
	assign mag = first_analog_input[ADC_W-2:0];
	// ref = max * gain/1000 * adc/full, gain at 10 V
	assign prod = (FREQ_W+GAIN_W+ADC_W-1)'(max_freq) * (FREQ_W+GAIN_W+ADC_W-1)'(gain)
		* (FREQ_W+GAIN_W+ADC_W-1)'(mag);
	assign scaled = prod / ((FREQ_W+GAIN_W+ADC_W-1)'(GAIN_UNITY)
		* (FREQ_W+GAIN_W+ADC_W-1)'(ADC_FULL));
	// saturate: gain up to 1000 % may exceed the frequency range
	assign mag_ref = (|scaled[FREQ_W+GAIN_W+ADC_W-2:FREQ_W]) ? {FREQ_W{1'b1}}
		: scaled[FREQ_W-1:0];

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			freq_ref <= '0;
		else
			freq_ref <= neg ? -$signed({1'b0, mag_ref}) : $signed({1'b0, mag_ref});
	end
endmodule : dsr_analog_ref
`default_nettype wire

/* hw/dsr_decel_ramp.sv */
// dsr_decel_ramp: deceleration ramp governor against dc bus overvoltage
// assumes bus voltage in volts and all inputs synchronous to clk
// Contract
// - Mode zero ramps down at the programmed rate regardless of bus voltage.
// - Mode one halts the ramp above the stall level and resumes below it.
// - Mode one resumes at the originally programmed deceleration rate.
// - Mode two adapts the rate for the shortest stop under the stall level.
// - Mode three is stall prevention for use with a braking resistor unit.
// - Mode accepts zero to three, resets to one, and only changes while stopped.
// - Stall level is 380 V low class, else 760 V at input >= 400 V, otherwise 660 V.
// - Flux vector and open-loop vector two ignore the mode setting.
// - Analog level select takes zero or one, resets to zero, zero is 11 bits plus sign.
// - Analog gain sets the 10 V reference, 0.0 to 1000.0 %, reset 100.0 %.
`default_nettype none
module dsr_decel_ramp
	import dsr_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic running,
	input wire logic cfg_we,
	input wire dsr_cfg_t cfg_in,
	input wire logic first_analog_level_select,
	input wire logic [GAIN_W-1:0] first_analog_gain,
	input wire logic [ADC_W-1:0] first_analog_input,
	input wire logic [FREQ_W-1:0] max_freq,
	input wire logic decel_req,
	input wire logic ramp_tick,
	input wire logic [RATE_W-1:0] decel_rate,
	input wire logic [FREQ_W-1:0] freq_load,
	input wire logic freq_load_en,
	input wire logic [VOLT_W-1:0] bus_voltage,
	output logic [FREQ_W-1:0] out_freq,
	output logic stall_hold,
	output logic [1:0] decel_stall_mode_display,
	output logic first_analog_level_display,
	output logic [GAIN_W-1:0] first_analog_gain_display,
	output logic signed [FREQ_W:0] freq_ref
);
	// ************************************************************
	// configuration
	// ************************************************************
	dsr_cfg_t cfg;
	logic level_sel;
	logic [GAIN_W-1:0] gain;
	logic [VOLT_W-1:0] stall_level;
	logic over;
	logic mode_active;
	logic [RATE_W-1:0] smart_rate;
	logic [RATE_W-1:0] next_step;

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cfg.mode <= dsr_mode_t'(MODE_RESET);
			cfg.high_class <= 1'b0;
			cfg.input_voltage_setting <= '0;
			cfg.ctrl <= DSR_VF;
		end
		else if (cfg_we && !running)
			cfg <= cfg_in; // two-bit field holds 0..3 only; locked while running
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			level_sel <= LEVEL_RESET;
			gain <= GAIN_RESET;
		end
		else
		begin
			if (cfg_we && !running)
				level_sel <= first_analog_level_select;
			// gain may change while running; out-of-range writes ignored
			if (cfg_we && first_analog_gain <= GAIN_MAX)
				gain <= first_analog_gain;
		end
	end

	function automatic logic [VOLT_W-1:0] stall_of(input dsr_cfg_t c);
		if (!c.high_class)
			return STALL_LOW_CLASS;
		return (c.input_voltage_setting >= INPUT_V_SPLIT) ? STALL_HIGH_HI : STALL_HIGH_LO;
	endfunction : stall_of

	assign stall_level = stall_of(cfg);
	assign over = bus_voltage > stall_level;
	assign mode_active = !(cfg.ctrl == DSR_FLUX || cfg.ctrl == DSR_OLV2);

	// ************************************************************
	// ramp
	// ************************************************************
	// mode three behaves as hold; the resistor absorbs most energy so holds are rare
	always_comb
	begin
		next_step = decel_rate;
		stall_hold = 1'b0;
		if (decel_req && mode_active)
		begin
			unique case (cfg.mode)
				DSR_OFF: next_step = decel_rate;
				DSR_HOLD, DSR_BRAKE:
				begin
					stall_hold = over;
					next_step = over ? '0 : decel_rate;
				end
				DSR_SMART:
				begin
					stall_hold = over;
					next_step = over ? '0 : smart_rate;
				end
			endcase
		end
	end

	// adaptive rate: grows while under the level, halves on each overshoot
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			smart_rate <= SMART_STEP;
		else if (!decel_req)
			smart_rate <= SMART_STEP;
		else if (ramp_tick && cfg.mode == DSR_SMART)
		begin
			if (over)
				smart_rate <= (smart_rate > SMART_STEP) ? smart_rate >> 1 : SMART_STEP;
			else if (smart_rate != {RATE_W{1'b1}})
				smart_rate <= smart_rate + SMART_STEP;
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			out_freq <= '0;
		else if (freq_load_en)
			out_freq <= freq_load;
		else if (decel_req && ramp_tick)
			out_freq <= (out_freq > next_step) ? out_freq - next_step : '0;
	end

	assign decel_stall_mode_display = cfg.mode;
	assign first_analog_level_display = level_sel;
	assign first_analog_gain_display = gain;

	dsr_analog_ref u_ref (
		.clk(clk),
		.sys_rst(sys_rst),
		.level_sel(level_sel),
		.gain(gain),
		.first_analog_input(first_analog_input),
		.max_freq(max_freq),
		.freq_ref(freq_ref)
	);

	// ************************************************************
	// checks
	// ************************************************************
	property p_hold_freezes;
		@(posedge clk) disable iff (sys_rst)
		(stall_hold && !freq_load_en) |=> out_freq == $past(out_freq);
	endproperty
	a_hold_freezes: assert property (p_hold_freezes) else $error("freq moved during hold");

	property p_mode1_hold;
		@(posedge clk) disable iff (sys_rst)
		(decel_req && mode_active && cfg.mode == DSR_HOLD) |-> stall_hold == over;
	endproperty
	a_mode1_hold: assert property (p_mode1_hold) else $error("mode one hold mismatch");

	property p_mode1_rate;
		@(posedge clk) disable iff (sys_rst)
		(decel_req && ramp_tick && !freq_load_en && cfg.mode == DSR_HOLD && !over
			&& out_freq > decel_rate) |=> out_freq == $past(out_freq) - $past(decel_rate);
	endproperty
	a_mode1_rate: assert property (p_mode1_rate) else $error("mode one rate wrong");

	property p_mode0;
		@(posedge clk) disable iff (sys_rst)
		(cfg.mode == DSR_OFF) |-> !stall_hold;
	endproperty
	a_mode0: assert property (p_mode0) else $error("mode zero held");

	property p_lock;
		@(posedge clk) disable iff (sys_rst)
		running |=> $stable(cfg.mode);
	endproperty
	a_lock: assert property (p_lock) else $error("mode changed while running");

	property p_level;
		@(posedge clk) disable iff (sys_rst)
		1'b1 |-> stall_level == (!cfg.high_class ? STALL_LOW_CLASS
			: (cfg.input_voltage_setting >= INPUT_V_SPLIT ? STALL_HIGH_HI : STALL_HIGH_LO));
	endproperty
	a_level: assert property (p_level) else $error("stall level wrong");

	property p_ignore;
		@(posedge clk) disable iff (sys_rst)
		!mode_active |-> !stall_hold;
	endproperty
	a_ignore: assert property (p_ignore) else $error("mode used under vector control");

	property p_gain_range;
		@(posedge clk) disable iff (sys_rst)
		1'b1 |-> gain <= GAIN_MAX;
	endproperty
	a_gain_range: assert property (p_gain_range) else $error("gain out of range");

	// mode zero never looks at the bus, so the step is the programmed one even when over
	property p_mode0_rate;
		@(posedge clk) disable iff (sys_rst)
		(decel_req && ramp_tick && !freq_load_en && cfg.mode == DSR_OFF
			&& out_freq > decel_rate) |=> out_freq == $past(out_freq) - $past(decel_rate);
	endproperty
	a_mode0_rate: assert property (p_mode0_rate) else $error("mode zero rate wrong");

	property p_brake_hold;
		@(posedge clk) disable iff (sys_rst)
		(decel_req && mode_active && cfg.mode == DSR_BRAKE && over) |-> stall_hold;
	endproperty
	a_brake_hold: assert property (p_brake_hold) else $error("mode three did not hold");
endmodule : dsr_decel_ramp
`default_nettype wire

/* tb/dsr_bus_model.sv */
// dsr_bus_model: dc bus voltage sensing in front of the ramp governor
// assumes the bench names the bus level to present
`default_nettype none
module dsr_bus_model
	import dsr_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [VOLT_W-1:0] bus_set,
	output logic [VOLT_W-1:0] bus_voltage
);
	timeunit 1ns;
	timeprecision 1ns;
	// ********
	// sensor path
	// ********
	// one cycle sensing delay, as a sampled converter would add
	always_ff @(posedge clk or posedge sys_rst)
		if (sys_rst)
			bus_voltage <= '0;
		else
			bus_voltage <= bus_set;
endmodule : dsr_bus_model
`default_nettype wire

/* tb/test_decel_overvoltage_stall_ramp.sv */
// test_decel_overvoltage_stall_ramp: self-checking bench of the ramp governor
// assumes one 25 MHz clock and the bus sensing model
`default_nettype none
module test_decel_overvoltage_stall_ramp
	import dsr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, sys_rst = 1, running = 0, cfg_we = 0, lvl = 0, decel_req = 0;
	logic ramp_tick = 0, load_en = 0, g_lvl = 0, hold, lvl_d;
	dsr_cfg_t cfg_in = '0;
	logic [GAIN_W-1:0] gain = 14'h03E8, g_gain = 14'h03E8, gain_d;
	logic [ADC_W-1:0] ain = '0;
	logic [FREQ_W-1:0] max_freq = '0, f_load = '0, out_freq, mf;
	logic [RATE_W-1:0] rate = '0;
	logic [VOLT_W-1:0] bus_set = '0, bus_v;
	logic [1:0] mode_d;
	logic signed [FREQ_W:0] freq_ref;
	logic [16:0] ex;
	logic [31:0] seed = 32'h0000016F;
	int num_errors = 0, comparisons = 0;
	// ********
	// harness
	// ********
	always #20 clk = ~clk;
	dsr_bus_model dsr_bus_model_i (.clk(clk), .sys_rst(sys_rst), .bus_set(bus_set),
		.bus_voltage(bus_v));
	dsr_decel_ramp dsr_decel_ramp_i (.clk(clk), .sys_rst(sys_rst), .running(running),
		.cfg_we(cfg_we), .cfg_in(cfg_in), .first_analog_level_select(lvl),
		.first_analog_gain(gain), .first_analog_input(ain), .max_freq(max_freq),
		.decel_req(decel_req), .ramp_tick(ramp_tick), .decel_rate(rate), .freq_load(f_load),
		.freq_load_en(load_en), .bus_voltage(bus_v), .out_freq(out_freq), .stall_hold(hold),
		.decel_stall_mode_display(mode_d), .first_analog_level_display(lvl_d),
		.first_analog_gain_display(gain_d), .freq_ref(freq_ref));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// reference from gain in 0.1 % steps and 10 V full scale, saturating
	function automatic logic [16:0] exp_ref(input logic [15:0] m, input logic [13:0] g,
		input logic l, input logic [11:0] a);
		logic [47:0] p;
		p = 48'(m) * 48'(g) * 48'(a[10:0]) / (48'(GAIN_UNITY) * 48'(ADC_FULL));
		if (p > 48'h0000FFFF)
			p = 48'h0000FFFF;
		return (a[11] && !l) ? 17'h0 - {1'h0, p[15:0]} : {1'h0, p[15:0]};
	endfunction : exp_ref
	task automatic close_out();
		$display("checks %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic cfg(input dsr_mode_t m, input logic hc, input logic [10:0] iv, input dsr_ctrl_t c);
		@(posedge clk);
		cfg_we <= 1'h1;
		cfg_in <= '{m, hc, iv, c};
		lvl <= g_lvl;
		gain <= g_gain;
		@(posedge clk);
		cfg_we <= 1'h0;
		cyc(2);
		#1;
	endtask : cfg
	// decel_req low also restarts the adaptive rate
	task automatic load();
		@(posedge clk);
		decel_req <= 1'h0;
		f_load <= 16'h8000 | 16'(rnd() & 32'h3FFF);
		rate <= 16'(rnd() & 32'hFF) + 16'h0001;
		load_en <= 1'h1;
		@(posedge clk);
		load_en <= 1'h0;
	endtask : load
	task automatic step(input logic [10:0] v, input logic hold_exp, input logic [15:0] drop);
		logic [FREQ_W-1:0] f0;
		@(posedge clk);
		bus_set <= v;
		decel_req <= 1'h1;
		cyc(2);
		#1;
		f0 = out_freq;
		chk({31'h0, hold}, {31'h0, hold_exp});
		@(posedge clk);
		ramp_tick <= 1'h1;
		@(posedge clk);
		ramp_tick <= 1'h0;
		#1;
		chk({16'h0, out_freq}, {16'h0, 16'(f0 - drop)});
	endtask : step
	// ********
	// scenarios
	// ********
	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		close_out();
	end
	initial
	begin
		cyc(8);
		sys_rst <= 1'h0;
		cyc(1);
		#1;
		chk({30'h0, mode_d}, 32'h1);
		chk({31'h0, lvl_d}, 32'h0);
		chk({18'h0, gain_d}, 32'h3E8);
		cfg(DSR_OFF, 1'h0, 11'h0, DSR_VF);
		chk({30'h0, mode_d}, 32'h0);
		load();
		step(11'h7FF, 1'h0, rate);
		for (int i = 0; i < 3; i++)
		begin
			ex = (i == 0) ? 17'h17C : (i == 1) ? 17'h2F8 : 17'h294;
			cfg(DSR_HOLD, i != 0, (i == 0) ? 11'(rnd()) : (i == 1) ? 11'h190 : 11'h18F, DSR_VF);
			load();
			step(11'(ex) + 11'h1, 1'h1, 16'h0);
			step(11'(ex), 1'h0, rate);
		end
		cfg(DSR_SMART, 1'h0, 11'h0, DSR_VF);
		load();
		step(11'h100, 1'h0, 16'h1);
		step(11'h100, 1'h0, 16'h2);
		step(11'h17D, 1'h1, 16'h0);
		step(11'h100, 1'h0, 16'h1);
		cfg(DSR_BRAKE, 1'h0, 11'h0, DSR_VF);
		step(11'h17D, 1'h1, 16'h0);
		for (int c = 3; c < 5; c++)
		begin
			cfg(DSR_HOLD, 1'h0, 11'h0, dsr_ctrl_t'(c));
			load();
			step(11'h7FF, 1'h0, rate);
		end
		@(posedge clk);
		running <= 1'h1;
		g_lvl = 1'h1;
		cfg(DSR_OFF, 1'h0, 11'h0, DSR_VF);
		chk({30'h0, mode_d}, 32'h1);
		chk({31'h0, lvl_d}, 32'h0);
		g_lvl = 1'h0;
		@(posedge clk);
		running <= 1'h0;
		mf = 16'(rnd() & 32'h3FFF);
		max_freq <= mf;
		ain <= 12'h7FF;
		cfg(DSR_HOLD, 1'h0, 11'h0, DSR_VF);
		chk({15'h0, freq_ref}, {16'h0, mf});
		@(posedge clk);
		ain <= 12'hFFF;
		cyc(2);
		#1;
		ex = 17'h0 - {1'h0, mf};
		chk({15'h0, freq_ref}, {15'h0, ex});
		g_lvl = 1'h1;
		g_gain = 14'h07D0;
		cfg(DSR_HOLD, 1'h0, 11'h0, DSR_VF);
		chk({15'h0, freq_ref}, {15'h0, mf, 1'h0});
		chk({31'h0, lvl_d}, 32'h1);
		g_gain = 14'h2711;
		cfg(DSR_HOLD, 1'h0, 11'h0, DSR_VF);
		chk({18'h0, gain_d}, 32'h7D0);
		// first pass is the saturating corner, the rest random
		for (int k = 0; k < 4; k++)
		begin
			g_gain = (k == 0) ? GAIN_MAX : 14'(rnd() % 32'h2711);
			g_lvl = k[0];
			@(posedge clk);
			max_freq <= (k == 0) ? 16'hFFFF : 16'(rnd());
			ain <= (k == 0) ? 12'h7FF : 12'(rnd());
			cfg(DSR_HOLD, 1'h0, 11'h0, DSR_VF);
			chk({18'h0, gain_d}, {18'h0, g_gain});
			chk({15'h0, freq_ref}, {15'h0, exp_ref(max_freq, g_gain, g_lvl, ain)});
		end
		close_out();
	end
endmodule : test_decel_overvoltage_stall_ramp
`default_nettype wire
